// >>> core/scsas_defines.svh
`ifndef SCSAS_DEFINES_SVH
`define SCSAS_DEFINES_SVH

// System clock and converter clock periods
`define SCSAS_CLK_NS 10
`define SCSAS_CONV_CLK_NS 500
`define SCSAS_DIV_CYCLES (`SCSAS_CONV_CLK_NS / `SCSAS_CLK_NS)

// Cycle budgets in converter clock ticks
`define SCSAS_CONV_TICKS 9'h018
`define SCSAS_CAL_TICKS 9'h12c

// Array and correction geometry
`define SCSAS_NSTAGE 4'h3
`define SCSAS_NCAL_LAST 3'h6
`define SCSAS_CAP_MSB 13'h1000
`define SCSAS_DAC_MSB 13'h0080
`define SCSAS_LAST_CAL_BIT 4'h6

// Reset values
`define SCSAS_NULL_RST 3'h7
`define SCSAS_DAC_RST 8'h00

`endif

// >>> core/scsas_pkg.sv
package scsas_pkg;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_CNULL   = 4'b0001,
    ST_CLOAD   = 4'b0010,
    ST_CSAMP   = 4'b0011,
    ST_CSAR    = 4'b0100,
    ST_KNULL   = 4'b0101,
    ST_KOFF    = 4'b0110,
    ST_KDIS    = 4'b0111,
    ST_KSET    = 4'b1000,
    ST_KRENULL = 4'b1001,
    ST_KZERO   = 4'b1010,
    ST_KSWAP   = 4'b1011,
    ST_KSAR    = 4'b1100,
    ST_PAD     = 4'b1101
  } scsas_state_type;

endpackage : scsas_pkg

// >>> core/scsas_seq.sv
`timescale 1ns/1ns
`include "scsas_defines.svh"

module scsas_seq (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // Commands from the host, same clock
  input wire logic CONV_START_I,
  input wire logic CAL_START_I,
  // Comparator output from the analog core
  input wire logic COMP_I,
  // Analog switch and DAC controls
  output logic IN_SHORT_O,
  output logic IN_CONNECT_O,
  output logic [2:0] NULL_SW_O,
  output logic [12:0] CAP_REF_O,
  output logic [7:0] CDAC_O,
  // Status and result to the host
  output logic BUSY_O,
  output logic [15:0] RESULT_O,
  output logic RESULT_VALID_O,
  output logic CAL_DONE_O,
  output logic CAL_VALID_O
);

  localparam logic [5:0] DIV_LAST = 6'(`SCSAS_DIV_CYCLES - 1);

  // Comparator synchroniser
  logic comp_s1_q;
  logic comp_s2_q;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
    end else begin
      comp_s1_q <= COMP_I;
      comp_s2_q <= comp_s1_q;
    end
  end

  // Converter clock enable
  logic [5:0] div_q;
  logic [5:0] div_d;
  logic ce_q;
  logic ce_d;

  always_comb begin
    ce_d = (div_q == DIV_LAST);
    div_d = ce_d ? 6'h00 : div_q + 6'h01;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      div_q <= 6'h00;
      ce_q <= 1'b0;
    end else begin
      div_q <= div_d;
      ce_q <= ce_d;
    end
  end

  // Sequencer state
  scsas_pkg::scsas_state_type st_q;
  scsas_pkg::scsas_state_type st_d;
  logic cal_q, cal_d;
  logic [8:0] tick_q, tick_d;
  logic [3:0] step_q, step_d;
  logic [3:0] bit_q, bit_d;
  logic [12:0] sar_q, sar_d;
  logic [2:0] pass_q, pass_d;
  logic [7:0] off_q, off_d;
  logic [7:0] err_q [7];
  logic [7:0] err_d [7];
  logic [7:0] acc_q, acc_d;
  logic short_q, short_d;
  logic conn_q, conn_d;
  logic [2:0] null_q, null_d;
  logic [12:0] capref_q, capref_d;
  logic [7:0] cdac_q, cdac_d;
  logic busy_q, busy_d;
  logic [15:0] res_q, res_d;
  logic rvalid_q, rvalid_d;
  logic cdone_q, cdone_d;
  logic calv_q, calv_d;
  logic [2:0] err_idx;
  logic [12:0] res_tc;

  always_comb begin
    st_d = st_q;
    cal_d = cal_q;
    tick_d = tick_q;
    step_d = step_q;
    bit_d = bit_q;
    sar_d = sar_q;
    pass_d = pass_q;
    off_d = off_q;
    err_d = err_q;
    acc_d = acc_q;
    short_d = short_q;
    conn_d = conn_q;
    null_d = null_q;
    capref_d = capref_q;
    cdac_d = cdac_q;
    busy_d = busy_q;
    res_d = res_q;
    rvalid_d = 1'b0;
    cdone_d = 1'b0;
    calv_d = calv_q;
    err_idx = 3'(4'hc - bit_q);
    res_tc = sar_q ^ `SCSAS_CAP_MSB;
    // A new command aborts whatever cycle is running
    if (CAL_START_I || CONV_START_I) begin
      st_d = CAL_START_I ? scsas_pkg::ST_KNULL : scsas_pkg::ST_CNULL;
      cal_d = CAL_START_I;
      tick_d = 9'h000;
      step_d = 4'h0;
      busy_d = 1'b1;
      conn_d = 1'b0;
      if (CAL_START_I) begin
        calv_d = 1'b0;
      end
    end else if (ce_q && st_q != scsas_pkg::ST_IDLE) begin
      tick_d = tick_q + 9'h001;
      step_d = step_q + 4'h1;
      unique case (st_q)
        scsas_pkg::ST_CNULL, scsas_pkg::ST_KNULL, scsas_pkg::ST_KRENULL: begin
          if (step_q == 4'h0) begin
            null_d = `SCSAS_NULL_RST;
            short_d = (st_q != scsas_pkg::ST_KRENULL);
            conn_d = 1'b0;
          end else begin
            null_d = null_q & ~(3'h1 << (step_q - 4'h1));
          end
          if (step_q == `SCSAS_NSTAGE) begin
            step_d = 4'h0;
            short_d = 1'b0;
            if (st_q == scsas_pkg::ST_CNULL) begin
              st_d = scsas_pkg::ST_CLOAD;
            end else if (st_q == scsas_pkg::ST_KNULL) begin
              st_d = scsas_pkg::ST_KOFF;
            end else begin
              st_d = scsas_pkg::ST_KZERO;
            end
          end
        end
        scsas_pkg::ST_CLOAD: begin
          cdac_d = off_q;
          acc_d = 8'h00;
          st_d = scsas_pkg::ST_CSAMP;
        end
        scsas_pkg::ST_CSAMP: begin
          conn_d = 1'b1;
          capref_d = 13'h0000;
          step_d = 4'h0;
          st_d = scsas_pkg::ST_CSAR;
        end
        scsas_pkg::ST_CSAR: begin
          conn_d = 1'b0;
          if (step_q == 4'h0) begin
            sar_d = `SCSAS_CAP_MSB;
            bit_d = 4'hc;
          end else begin
            if (!comp_s2_q) begin
              sar_d[bit_q] = 1'b0;
            end else if (bit_q >= `SCSAS_LAST_CAL_BIT) begin
              acc_d = acc_q + err_q[err_idx];
            end
            if (bit_q == 4'h0) begin
              st_d = scsas_pkg::ST_PAD;
            end else begin
              bit_d = bit_q - 4'h1;
              sar_d[bit_d] = 1'b1;
            end
          end
          capref_d = sar_d;
          cdac_d = off_q + acc_d;
        end
        scsas_pkg::ST_KOFF, scsas_pkg::ST_KSAR: begin
          // 8-bit approximation on the correction DACs
          if (step_q == 4'h0) begin
            sar_d = `SCSAS_DAC_MSB;
            bit_d = 4'h7;
          end else begin
            if (!comp_s2_q) begin
              sar_d[bit_q] = 1'b0;
            end
            if (bit_q == 4'h0) begin
              step_d = 4'h0;
              st_d = scsas_pkg::ST_KDIS;
              if (st_q == scsas_pkg::ST_KOFF) begin
                off_d = sar_d[7:0];
                pass_d = 3'h0;
              end else begin
                err_d[pass_q] = sar_d[7:0];
                if (pass_q == `SCSAS_NCAL_LAST) begin
                  st_d = scsas_pkg::ST_PAD;
                end else begin
                  pass_d = pass_q + 3'h1;
                end
              end
            end else begin
              bit_d = bit_q - 4'h1;
              sar_d[bit_d] = 1'b1;
            end
          end
          cdac_d = (st_q == scsas_pkg::ST_KOFF) ? sar_d[7:0] : sar_d[7:0] - off_q;
        end
        scsas_pkg::ST_KDIS: begin
          conn_d = 1'b0;
          short_d = 1'b0;
          st_d = scsas_pkg::ST_KSET;
        end
        scsas_pkg::ST_KSET: begin
          capref_d = `SCSAS_CAP_MSB >> pass_q;
          cdac_d = off_q;
          step_d = 4'h0;
          st_d = scsas_pkg::ST_KRENULL;
        end
        scsas_pkg::ST_KZERO: begin
          cdac_d = `SCSAS_DAC_RST;
          st_d = scsas_pkg::ST_KSWAP;
        end
        scsas_pkg::ST_KSWAP: begin
          // Higher caps already measured stay grounded
          capref_d = (`SCSAS_CAP_MSB >> pass_q) - 13'h0001;
          cdac_d = 8'h00 - off_q;
          step_d = 4'h0;
          st_d = scsas_pkg::ST_KSAR;
        end
        scsas_pkg::ST_PAD: begin
          // Idle out the rest of the fixed budget
          if (tick_q == (cal_q ? `SCSAS_CAL_TICKS : `SCSAS_CONV_TICKS) - 9'h001) begin
            tick_d = tick_q;
            st_d = scsas_pkg::ST_IDLE;
            busy_d = 1'b0;
            capref_d = 13'h0000;
            cdac_d = `SCSAS_DAC_RST;
            if (cal_q) begin
              cdone_d = 1'b1;
              calv_d = 1'b1;
            end else begin
              res_d = {{3{res_tc[12]}}, res_tc};
              rvalid_d = 1'b1;
            end
          end
        end
        default: begin
          st_d = scsas_pkg::ST_IDLE;
          busy_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_q <= scsas_pkg::ST_IDLE;
      cal_q <= 1'b0;
      tick_q <= 9'h000;
      step_q <= 4'h0;
      bit_q <= 4'h0;
      sar_q <= 13'h0000;
      pass_q <= 3'h0;
      off_q <= 8'h00;
      for (int i = 0; i < 7; i++) begin
        err_q[i] <= 8'h00;
      end
      acc_q <= 8'h00;
      short_q <= 1'b0;
      conn_q <= 1'b0;
      null_q <= `SCSAS_NULL_RST;
      capref_q <= 13'h0000;
      cdac_q <= `SCSAS_DAC_RST;
      busy_q <= 1'b0;
      res_q <= 16'h0000;
      rvalid_q <= 1'b0;
      cdone_q <= 1'b0;
      calv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cal_q <= cal_d;
      tick_q <= tick_d;
      step_q <= step_d;
      bit_q <= bit_d;
      sar_q <= sar_d;
      pass_q <= pass_d;
      off_q <= off_d;
      err_q <= err_d;
      acc_q <= acc_d;
      short_q <= short_d;
      conn_q <= conn_d;
      null_q <= null_d;
      capref_q <= capref_d;
      cdac_q <= cdac_d;
      busy_q <= busy_d;
      res_q <= res_d;
      rvalid_q <= rvalid_d;
      cdone_q <= cdone_d;
      calv_q <= calv_d;
    end
  end

  assign IN_SHORT_O = short_q;
  assign IN_CONNECT_O = conn_q;
  assign NULL_SW_O = null_q;
  assign CAP_REF_O = capref_q;
  assign CDAC_O = cdac_q;
  assign BUSY_O = busy_q;
  assign RESULT_O = res_q;
  assign RESULT_VALID_O = rvalid_q;
  assign CAL_DONE_O = cdone_q;
  assign CAL_VALID_O = calv_q;

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  conv_budget_a: assert property (RESULT_VALID_O |-> tick_q == 9'h017 && !cal_q)
    else $error("conversion did not take 24 ticks");
  cal_budget_a: assert property (CAL_DONE_O |-> tick_q == 9'h12b && pass_q == 3'h6)
    else $error("calibration did not take 300 ticks over seven passes");
  cal_no_sample_a: assert property (busy_q && cal_q |-> !IN_CONNECT_O)
    else $error("inputs sampled during calibration");
  cmd_start_a: assert property ((CAL_START_I || CONV_START_I) |=> BUSY_O && tick_q == 9'h000)
    else $error("command not accepted");
  result_sign_a: assert property (RESULT_VALID_O |-> RESULT_O[15:13] == {3{RESULT_O[12]}})
    else $error("result not sign extended");
  null_close_a: assert property (st_q == scsas_pkg::ST_CNULL && ce_q && step_q == 4'h0
    && !CAL_START_I && !CONV_START_I |=> NULL_SW_O == 3'h7 && IN_SHORT_O ##50 NULL_SW_O == 3'h6)
    else $error("coarse null sequence wrong");
  pass_disc_a: assert property (st_q == scsas_pkg::ST_KDIS && ce_q |=> !IN_CONNECT_O)
    else $error("inputs not disconnected");
  cap_set_a: assert property (st_q == scsas_pkg::ST_KSET && ce_q && !CAL_START_I
    && !CONV_START_I |=> CAP_REF_O == (13'h1000 >> pass_q) && CDAC_O == off_q)
    else $error("capacitor under test not on reference");
  cap_swap_a: assert property (st_q == scsas_pkg::ST_KSWAP && ce_q && !CAL_START_I
    && !CONV_START_I |=> CAP_REF_O == (13'h1000 >> pass_q) - 13'h0001)
    else $error("swap connections wrong");
  off_load_a: assert property (st_q == scsas_pkg::ST_CLOAD && ce_q && !CAL_START_I
    && !CONV_START_I |=> CDAC_O == off_q)
    else $error("offset not loaded");
  table_keep_a: assert property (CAL_VALID_O && !CAL_START_I |=> CAL_VALID_O && $stable(off_q))
    else $error("calibration table lost");

  conv_done_c: cover property (RESULT_VALID_O);
  cal_done_c: cover property (CAL_DONE_O);
  abort_c: cover property (BUSY_O && CONV_START_I);
  conv_after_cal_c: cover property (CAL_VALID_O && RESULT_VALID_O);

endmodule : scsas_seq

// >>> bench/scsas_analog_model.sv
`timescale 1ns/1ns
// Ideal comparator behind the arrays, offset taken as zero
module scsas_analog_model (
  // Array controls from the sequencer
  input wire logic in_connect_i,
  input wire logic [12:0] cap_ref_i,
  // Offset-binary input level
  input wire logic [12:0] level_i,
  // Comparator decision
  output logic comp_o
);
  logic [12:0] held;

  // Known start level, so calibration decisions never go unknown
  initial held = 13'h0000;

  // Charge follows the inputs only while connected
  always @* begin
    if (in_connect_i) begin
      held = level_i;
    end
  end

  // Keep the trial bit while the sample is at or above it
  assign comp_o = (held >= cap_ref_i);
endmodule : scsas_analog_model

// >>> bench/scsas_seq_tb.sv
`timescale 1ns/1ns
module scsas_seq_tb;
  logic CLK_I = 1'b0;
  logic RSTN_I = 1'b0;
  logic CONV_START_I = 1'b0;
  logic CAL_START_I = 1'b0;
  logic COMP_I;
  logic IN_SHORT_O, IN_CONNECT_O, BUSY_O, RESULT_VALID_O, CAL_DONE_O, CAL_VALID_O;
  logic [2:0] NULL_SW_O;
  logic [12:0] CAP_REF_O;
  logic [7:0] CDAC_O;
  logic [15:0] RESULT_O;
  logic [12:0] level = 13'h1000;
  int num_errors = 0;
  int n_checks = 0;
  int n, conn, bad_conn, busy_gap, n_res, n_done;
  logic [7:0] nmask, cdac_seen;
  logic [6:0] cmask, smask;
  logic short_ok, dac_mid;
  logic [12:0] vals [5] = '{13'h0fff, 13'h1000, 13'h1ffb, 13'h0000, 13'h0123};

  always #5 CLK_I = ~CLK_I;

  scsas_seq scsas_seq_i (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .CONV_START_I(CONV_START_I),
    .CAL_START_I(CAL_START_I), .COMP_I(COMP_I), .IN_SHORT_O(IN_SHORT_O),
    .IN_CONNECT_O(IN_CONNECT_O), .NULL_SW_O(NULL_SW_O), .CAP_REF_O(CAP_REF_O),
    .CDAC_O(CDAC_O), .BUSY_O(BUSY_O), .RESULT_O(RESULT_O),
    .RESULT_VALID_O(RESULT_VALID_O), .CAL_DONE_O(CAL_DONE_O), .CAL_VALID_O(CAL_VALID_O));

  scsas_analog_model scsas_analog_model_i (.in_connect_i(IN_CONNECT_O),
    .cap_ref_i(CAP_REF_O), .level_i(level), .comp_o(COMP_I));

  task finish_test;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One-cycle strobe, taken at the edge that lowers it
  task pulse(input logic cal);
    @(posedge CLK_I);
    CAL_START_I <= cal;
    CONV_START_I <= !cal;
    @(posedge CLK_I);
    CAL_START_I <= 1'b0;
    CONV_START_I <= 1'b0;
  endtask : pulse

  // Issue a command and watch every cycle until its closing pulse
  task run(input logic cal, input int lo, input int hi);
    logic fin;
    {conn, bad_conn, busy_gap, n_res, n_done} = '0;
    {nmask, cdac_seen, cmask, smask, short_ok, dac_mid} = '0;
    pulse(cal);
    for (n = 1; n <= hi + 10; n++) begin
      @(posedge CLK_I);
      #1;
      fin = cal ? CAL_DONE_O : RESULT_VALID_O;
      nmask[NULL_SW_O] = 1'b1;
      if (IN_SHORT_O && NULL_SW_O == 3'h7) short_ok = 1'b1;
      if (IN_CONNECT_O) conn++;
      if (IN_CONNECT_O && (IN_SHORT_O || NULL_SW_O != 3'h0)) bad_conn++;
      if (!BUSY_O && !fin) busy_gap++;
      if (RESULT_VALID_O) n_res++;
      if (CAL_DONE_O) n_done++;
      if (CDAC_O == 8'h80) dac_mid = 1'b1;
      // Last correction code before the end clears it
      if (BUSY_O && !fin) cdac_seen = CDAC_O;
      for (int p = 0; p < 7; p++) begin
        if (CAP_REF_O == (13'h1000 >> p)) cmask[p] = 1'b1;
        if (CAP_REF_O == (13'h1000 >> p) - 13'h0001) smask[p] = 1'b1;
      end
      if (n == 1) check(16'(BUSY_O), 16'h0001);
      if (fin) break;
    end
    if (n > hi + 10) begin
      num_errors++;
      finish_test;
    end else begin
      check(16'(n >= lo && n <= hi), 16'h0001);
      check(16'(BUSY_O), 16'h0000);
      check(16'(nmask), 16'h00d1);
      check(16'(short_ok), 16'h0001);
      check(16'(busy_gap), 16'h0000);
    end
  endtask : run

  task t_reset;
    check({IN_SHORT_O, IN_CONNECT_O, BUSY_O, RESULT_VALID_O, CAL_DONE_O, CAL_VALID_O,
      7'h00, NULL_SW_O}, 16'h0007);
    check(RESULT_O, 16'h0000);
    check({CDAC_O, 8'h00}, 16'h0000);
    check(16'(CAP_REF_O), 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task t_cal;
    run(1'b1, 14951, 15001);
    check(16'(conn), 16'h0000);
    check(16'(n_res), 16'h0000);
    check(16'(cmask), 16'h007f);
    check(16'(smask), 16'h007f);
    check(16'(dac_mid), 16'h0001);
    check(16'(CAL_VALID_O), 16'h0001);
    $display("test calibration done");
  endtask : t_cal

  // Extremes of the signed range and a few inner codes
  task t_conv;
    for (int i = 0; i < 5; i++) begin
      level <= vals[i] ^ 13'h1000;
      run(1'b0, 1151, 1201);
      check(RESULT_O, {{3{vals[i][12]}}, vals[i]});
      check(16'(conn > 0 && bad_conn == 0), 16'h0001);
      check(16'(n_done), 16'h0000);
      // Model never trips the error passes here, so only the offset code remains
      check(16'(cdac_seen), 16'h00ff);
      check(16'(CAL_VALID_O), 16'h0001);
    end
    $display("test conversion done");
  endtask : t_conv

  // Conversion cut short by calibration leaves no result
  task t_abort_conv;
    pulse(1'b0);
    repeat (300) @(posedge CLK_I);
    t_cal;
    $display("test conversion abort done");
  endtask : t_abort_conv

  // Calibration cut short: table stays invalid, no done pulse
  task t_abort_cal;
    level <= 13'h1005;
    pulse(1'b1);
    repeat (2000) @(posedge CLK_I);
    #1;
    check(16'(CAL_VALID_O), 16'h0000);
    run(1'b0, 1151, 1201);
    check(RESULT_O, 16'h0005);
    // Offset ff plus the kept top bit's error ff, wrapped to eight bits
    check(16'(cdac_seen), 16'h00fe);
    check(16'(n_done), 16'h0000);
    check(16'(CAL_VALID_O), 16'h0000);
    $display("test calibration abort done");
  endtask : t_abort_cal

  initial begin
    repeat (4) @(posedge CLK_I);
    t_reset;
    RSTN_I <= 1'b1;
    t_cal;
    t_conv;
    t_abort_conv;
    t_abort_cal;
    finish_test;
  end
endmodule : scsas_seq_tb
